// >>> hw/cal_clock.sv
// calendar clock with monitor, setting and control words
`timescale 1ns/1ps
`default_nettype none
`include "cal_clock_regs.svh"

module cal_clock #(
   parameter int SEC_CYCLES = `SEC_CYCLES
) (
   input wire logic ref_clk,
   input wire logic reset,
   input wire cal_clock_pkg::reg_wr_t wr_req,
   input wire logic [16:0] rd_addr,
   output logic [15:0] rd_data_r,
   output cal_clock_pkg::clock_time_t time_r,
   output logic sec_tick_r
);
   import cal_clock_pkg::*;

   localparam int CNT_W = $clog2(SEC_CYCLES);

   // a one-cycle second leaves the counter no room to wrap
   if (SEC_CYCLES < 2) begin : g_cycles_check
      $error("SEC_CYCLES must be at least 2");
   end

   byte_pair_t set_ms_r;
   byte_pair_t set_dh_r;
   byte_pair_t set_ym_r;
   byte_pair_t set_wd_r;
   logic [15:0] ctrl_r;
   state_t st_r;
   state_t st_nxt;
   clock_time_t time_nxt;
   logic [CNT_W-1:0] cnt_r;
   logic [7:0] day_max;
   logic leap;
   logic tick_en;
   logic round_up;
   logic wr_ctrl;
   logic wr_set;
   logic c_s, c_m, c_h, c_d, c_mo;
   logic [7:0] n_s, n_m, n_h, n_d, n_mo, n_y, n_wd;

   // ***********************************************************
   // one-second time base
   // ***********************************************************
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         cnt_r <= '0;
         sec_tick_r <= 1'b0;
      end else if (cnt_r == CNT_W'(SEC_CYCLES - 1)) begin
         cnt_r <= '0;
         sec_tick_r <= 1'b1;
      end else begin
         cnt_r <= CNT_W'(cnt_r + 1'b1);
         sec_tick_r <= 1'b0;
      end
   end

   // ***********************************************************
   // calendar increment chain
   // ***********************************************************
   // a tick landing on a load, tool or rounding cycle is dropped; all three rewrite the seconds anyway
   assign tick_en = sec_tick_r && (st_r == st_idle);
   assign round_up = (st_r == st_round) && (time_r.sec >= `ROUND_THRESH);

   // years 00 to 99 stand for 2000 to 2099, where every fourth year is leap
   always_comb begin
      leap = (!time_r.year[4] && (time_r.year[3:0] == 4'h0 || time_r.year[3:0] == 4'h4
              || time_r.year[3:0] == 4'h8))
             || (time_r.year[4] && (time_r.year[3:0] == 4'h2 || time_r.year[3:0] == 4'h6));
      if (time_r.month == `MONTH_FEB) begin
         day_max = leap ? `DAY_29 : `DAY_28;
      end else if (time_r.month == `MONTH_APR || time_r.month == `MONTH_JUN
                   || time_r.month == `MONTH_SEP || time_r.month == `MONTH_NOV) begin
         day_max = `DAY_30;
      end else begin
         day_max = `DAY_31;
      end
   end

   bcd_step u_sec (
      .val(time_r.sec), .lo(`ZERO), .hi(`SEC_MAX), .en(tick_en), .nxt(n_s), .carry(c_s)
   );
   bcd_step u_min (
      .val(time_r.min), .lo(`ZERO), .hi(`MIN_MAX), .en(c_s || round_up), .nxt(n_m), .carry(c_m)
   );
   bcd_step u_hour (
      .val(time_r.hour), .lo(`ZERO), .hi(`HOUR_MAX), .en(c_m), .nxt(n_h), .carry(c_h)
   );
   bcd_step u_day (
      .val(time_r.day), .lo(`DAY_MIN), .hi(day_max), .en(c_h), .nxt(n_d), .carry(c_d)
   );
   bcd_step u_month (
      .val(time_r.month), .lo(`MONTH_MIN), .hi(`MONTH_MAX), .en(c_d), .nxt(n_mo), .carry(c_mo)
   );
   bcd_step u_year (
      .val(time_r.year), .lo(`ZERO), .hi(`YEAR_MAX), .en(c_mo), .nxt(n_y), .carry()
   );
   bcd_step u_wday (
      .val(time_r.wday), .lo(`ZERO), .hi(`WDAY_MAX), .en(c_h), .nxt(n_wd), .carry()
   );

   // ***********************************************************
   // running clock
   // ***********************************************************
   always_comb begin
      time_nxt = '{sec: n_s, min: n_m, hour: n_h, day: n_d, month: n_mo, year: n_y, wday: n_wd};
      case (st_r)
         st_load, st_tool: begin
            time_nxt = '{sec: set_ms_r.lo, min: set_ms_r.hi, hour: set_dh_r.lo, day: set_dh_r.hi,
                         month: set_ym_r.lo, year: set_ym_r.hi, wday: set_wd_r.lo};
         end
         st_round: begin
            time_nxt.sec = `ZERO;
         end
         default: begin
            time_nxt.sec = n_s;
         end
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         time_r <= '{sec: `ZERO, min: `ZERO, hour: `ZERO, day: `DAY_MIN, month: `MONTH_MIN,
                     year: `ZERO, wday: `ZERO};
      end else begin
         time_r <= time_nxt;
      end
   end

   // ***********************************************************
   // register writes and action sequencing
   // ***********************************************************
   assign wr_ctrl = wr_req.wr && (wr_req.addr == `ADDR_CTRL);
   assign wr_set = wr_req.wr && (wr_req.addr == `ADDR_SET_MS || wr_req.addr == `ADDR_SET_DH
                   || wr_req.addr == `ADDR_SET_YM || wr_req.addr == `ADDR_SET_WD);

   always_comb begin
      st_nxt = st_idle;
      if (wr_ctrl && wr_req.data[`CTRL_LOAD_BIT]) begin
         st_nxt = st_load;
      end else if (wr_ctrl && wr_req.data[`CTRL_ROUND_BIT]) begin
         st_nxt = st_round;
      end else if (wr_set && wr_req.tool) begin
         st_nxt = st_tool;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         st_r <= st_idle;
      end else begin
         st_r <= st_nxt;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         set_ms_r <= '{hi: `ZERO, lo: `ZERO};
         set_dh_r <= '{hi: `DAY_MIN, lo: `ZERO};
         set_ym_r <= '{hi: `ZERO, lo: `MONTH_MIN};
         set_wd_r <= '{hi: `ZERO, lo: `ZERO};
      end else if (wr_req.wr) begin
         // the monitor address has no storage, so a write there falls through
         case (wr_req.addr)
            `ADDR_SET_MS: begin
               set_ms_r <= wr_req.data;
            end
            `ADDR_SET_DH: begin
               set_dh_r <= wr_req.data;
            end
            `ADDR_SET_YM: begin
               set_ym_r <= wr_req.data;
            end
            `ADDR_SET_WD: begin
               set_wd_r <= wr_req.data;
            end
            default: begin
            end
         endcase
      end
   end

   // a fresh write in the finishing cycle wins over the self-clear
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         ctrl_r <= `CTRL_CLEAR;
      end else if (wr_ctrl) begin
         ctrl_r <= wr_req.data;
      end else if (st_r == st_load || st_r == st_round) begin
         ctrl_r <= `CTRL_CLEAR;
      end
   end

   // ***********************************************************
   // register reads
   // ***********************************************************
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         rd_data_r <= '0;
      end else begin
         case (rd_addr)
            `ADDR_MONITOR: begin
               rd_data_r <= {time_r.hour, time_r.min};
            end
            `ADDR_SET_MS: begin
               rd_data_r <= set_ms_r;
            end
            `ADDR_SET_DH: begin
               rd_data_r <= set_dh_r;
            end
            `ADDR_SET_YM: begin
               rd_data_r <= set_ym_r;
            end
            `ADDR_SET_WD: begin
               rd_data_r <= set_wd_r;
            end
            `ADDR_CTRL: begin
               rd_data_r <= ctrl_r;
            end
            default: begin
               rd_data_r <= '0;
            end
         endcase
      end
   end

   // ***********************************************************
   // assertions
   // ***********************************************************
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (reset);

   sequence s_ctrl_load;
      wr_ctrl && wr_req.data[`CTRL_LOAD_BIT];
   endsequence

   sequence s_ctrl_round;
      wr_ctrl && !wr_req.data[`CTRL_LOAD_BIT] && wr_req.data[`CTRL_ROUND_BIT];
   endsequence

   property p_monitor_read;
      rd_addr == `ADDR_MONITOR |=> rd_data_r == {$past(time_r.hour), $past(time_r.min)};
   endproperty
   a_monitor_read: assert property (p_monitor_read) else $error("monitor word mismatch");

   property p_monitor_nowrite;
      wr_req.wr && wr_req.addr == `ADDR_MONITOR && st_r == st_idle && !sec_tick_r
         |=> $stable(time_r.hour) && $stable(time_r.min);
   endproperty
   a_monitor_nowrite: assert property (p_monitor_nowrite) else $error("monitor write changed time");

   property p_ranges;
      time_r.sec <= `SEC_MAX && time_r.hour <= `HOUR_MAX && time_r.wday <= `WDAY_MAX
         && time_r.month >= `MONTH_MIN && time_r.month <= `MONTH_MAX && time_r.day >= `DAY_MIN
         || $past(st_r) != st_idle;
   endproperty
   a_ranges: assert property (p_ranges) else $error("clock field out of range");

   property p_february;
      time_r.month == `MONTH_FEB && time_r.day == `DAY_28 && !leap && sec_tick_r && st_r == st_idle
         && time_r.hour == `HOUR_MAX && time_r.min == `MIN_MAX && time_r.sec == `SEC_MAX
         |=> time_r.day == `DAY_MIN && time_r.month == `MONTH_MAR;
   endproperty
   a_february: assert property (p_february) else $error("february did not end on the 28th");

   property p_load;
      s_ctrl_load ##1 !wr_req.wr |=> time_r.min == $past(set_ms_r.hi) && time_r.sec == $past(set_ms_r.lo)
         && time_r.year == $past(set_ym_r.hi);
   endproperty
   a_load: assert property (p_load) else $error("control load did not copy setting words");

   property p_load_clear;
      s_ctrl_load ##1 !wr_ctrl |=> ctrl_r == `CTRL_CLEAR;
   endproperty
   a_load_clear: assert property (p_load_clear) else $error("control word not cleared after load");

   property p_round_zero;
      s_ctrl_round ##1 !wr_req.wr |=> time_r.sec == `ZERO && ctrl_r == `CTRL_CLEAR;
   endproperty
   a_round_zero: assert property (p_round_zero) else $error("seconds not zero after correction");

   property p_round_down;
      st_r == st_round && time_r.sec < `ROUND_THRESH |=> $stable(time_r.min) && $stable(time_r.hour);
   endproperty
   a_round_down: assert property (p_round_down) else $error("truncation moved the minute");

   property p_round_up;
      st_r == st_round && time_r.sec >= `ROUND_THRESH && time_r.min[3:0] != `DIGIT_NINE
         |=> time_r.min == 8'($past(time_r.min) + 8'h01);
   endproperty
   a_round_up: assert property (p_round_up) else $error("rounding did not carry the minute");

   property p_tool_load;
      wr_req.wr && wr_req.tool && wr_req.addr == `ADDR_SET_MS ##1 !wr_req.wr
         |=> time_r.min == $past(wr_req.data.hi, 2) && time_r.sec == $past(wr_req.data.lo, 2);
   endproperty
   a_tool_load: assert property (p_tool_load) else $error("tool write not applied at once");

   property p_sec_roll;
      sec_tick_r && st_r == st_idle && time_r.sec == `SEC_MAX |=> time_r.sec == `ZERO && $changed(time_r.min);
   endproperty
   a_sec_roll: assert property (p_sec_roll) else $error("seconds did not roll into minutes");

endmodule // cal_clock

`default_nettype wire

// >>> hw/cal_clock_regs.svh
// address map, field values and timing constants of the calendar clock
`ifndef CAL_CLOCK_REGS_SVH
`define CAL_CLOCK_REGS_SVH

// ***********************************************************
// data register numbers (decimal 90053 to 90058)
// ***********************************************************
`define ADDR_W 17
`define ADDR_MONITOR 17'h15fc5
`define ADDR_SET_MS 17'h15fc6
`define ADDR_SET_DH 17'h15fc7
`define ADDR_SET_YM 17'h15fc8
`define ADDR_SET_WD 17'h15fc9
`define ADDR_CTRL 17'h15fca

// ***********************************************************
// control word bits
// ***********************************************************
`define CTRL_LOAD_BIT 15
`define CTRL_ROUND_BIT 0
`define CTRL_CLEAR 16'h0000

// ***********************************************************
// two-digit hex-coded field limits and reset values
// ***********************************************************
`define ZERO 8'h00
`define SEC_MAX 8'h59
`define MIN_MAX 8'h59
`define HOUR_MAX 8'h23
`define DAY_MIN 8'h01
`define DAY_28 8'h28
`define DAY_29 8'h29
`define DAY_30 8'h30
`define DAY_31 8'h31
`define MONTH_MIN 8'h01
`define MONTH_MAX 8'h12
`define MONTH_FEB 8'h02
`define MONTH_MAR 8'h03
`define MONTH_APR 8'h04
`define MONTH_JUN 8'h06
`define MONTH_SEP 8'h09
`define MONTH_NOV 8'h11
`define YEAR_MAX 8'h99
`define WDAY_MAX 8'h06
`define ROUND_THRESH 8'h30
`define DIGIT_NINE 4'h9

// ***********************************************************
// one-second time base
// ***********************************************************
`define TICK_PERIOD_NS 32'h3b9aca00
`define CLK_PERIOD_NS 32'h00000064
`define SEC_CYCLES (`TICK_PERIOD_NS / `CLK_PERIOD_NS)

`endif

// >>> hw/cal_clock_pkg.sv
// types shared by the calendar clock files
package cal_clock_pkg;

   typedef struct packed {
      logic [7:0] hi;
      logic [7:0] lo;
   } byte_pair_t;

   typedef struct packed {
      logic wr;
      logic tool;
      logic [16:0] addr;
      byte_pair_t data;
   } reg_wr_t;

   typedef struct packed {
      logic [7:0] sec;
      logic [7:0] min;
      logic [7:0] hour;
      logic [7:0] day;
      logic [7:0] month;
      logic [7:0] year;
      logic [7:0] wday;
   } clock_time_t;

   typedef enum logic [3:0] {
      st_idle = 4'b0001,
      st_load = 4'b0010,
      st_round = 4'b0100,
      st_tool = 4'b1000
   } state_t;

endpackage

// >>> hw/bcd_step.sv
// one two-digit hex-coded counter stage with wrap and carry
`timescale 1ns/1ps
`default_nettype none
`include "cal_clock_regs.svh"

module bcd_step (
   input wire logic [7:0] val,
   input wire logic [7:0] lo,
   input wire logic [7:0] hi,
   input wire logic en,
   output logic [7:0] nxt,
   output logic carry
);
   logic [7:0] inc;

   always_comb begin
      if (val[3:0] == `DIGIT_NINE) begin
         inc = {4'(val[7:4] + 4'h1), 4'h0};
      end else begin
         inc = {val[7:4], 4'(val[3:0] + 4'h1)};
      end
      // >= so an out-of-range value left by a month change still wraps
      carry = en && (val >= hi);
      if (!en) begin
         nxt = val;
      end else if (carry) begin
         nxt = lo;
      end else begin
         nxt = inc;
      end
   end
endmodule // bcd_step

`default_nettype wire

// >>> tb/test_cal_clock.sv
// self-checking bench for the calendar clock registers
`timescale 1ns/1ps
`default_nettype none
`include "cal_clock_regs.svh"

module test_cal_clock;
   import cal_clock_pkg::*;

   // ***********************************************************
   // signals and design instance
   // ***********************************************************
   // short second so each set_time sequence fits between two ticks
   localparam int SEC_N = 20;
   logic ref_clk;
   logic reset;
   reg_wr_t wr_req;
   logic [16:0] rd_addr;
   logic [15:0] rd_data_r;
   clock_time_t time_r;
   logic sec_tick_r;
   int errors;
   int n_checks;
   logic [15:0] rd_val;
   logic [15:0] rst_tab [6] = '{16'h0000, 16'h0000, 16'h0100, 16'h0001, 16'h0000, 16'h0000};
   // day, month, year before the last second, then day, month, year after it
   logic [47:0] roll_tab [7] = '{48'h28_02_24_29_02_24, 48'h28_02_23_01_03_23, 48'h29_02_24_01_03_24,
      48'h30_04_23_01_05_23, 48'h31_12_23_01_01_24, 48'h31_01_00_01_02_00, 48'h28_02_00_29_02_00};
   // minute, second before rounding, then hour, minute after it
   logic [31:0] round_tab [4] = '{32'h05_29_10_05, 32'h05_35_10_06, 32'h05_30_10_06, 32'h59_45_11_00};

   cal_clock #(.SEC_CYCLES(SEC_N)) dut (
      .ref_clk(ref_clk),
      .reset(reset),
      .wr_req(wr_req),
      .rd_addr(rd_addr),
      .rd_data_r(rd_data_r),
      .time_r(time_r),
      .sec_tick_r(sec_tick_r)
   );

   initial ref_clk = 1'b0;
   always #50 ref_clk = ~ref_clk;

   // ***********************************************************
   // access tasks
   // ***********************************************************
   task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp) begin
         errors++;
         $display("unexpected %s: expected %h, seen %h", what, exp, seen);
      end
   endtask

   task automatic end_sim;
      $display("checks %0d, mismatches %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // one word move; an idle cycle follows so the strobe is never re-raised in the same step
   task automatic wr_word(input logic [16:0] a, input logic [15:0] d, input logic tl);
      @(negedge ref_clk);
      wr_req.wr = 1'b1;
      wr_req.tool = tl;
      wr_req.addr = a;
      wr_req.data = d;
      @(negedge ref_clk);
      wr_req.wr = 1'b0;
   endtask

   task automatic rd_word(input logic [16:0] a, output logic [15:0] v);
      @(negedge ref_clk);
      rd_addr = a;
      @(negedge ref_clk);
      v = rd_data_r;
   endtask

   // actions land one edge after the write edge; two edges are waited
   task automatic settle;
      @(posedge ref_clk);
      @(posedge ref_clk);
      @(negedge ref_clk);
   endtask

   task automatic wait_tick;
      int n;
      n = 0;
      @(negedge ref_clk);
      while (sec_tick_r !== 1'b1 && n < 4 * SEC_N) begin
         @(negedge ref_clk);
         n++;
      end
      chk("second tick", {15'h0000, sec_tick_r}, 16'h0001);
   endtask

   // seconds count up at the edge after the tick
   task automatic adv;
      wait_tick();
      @(posedge ref_clk);
      @(negedge ref_clk);
   endtask

   // starts just after a tick so no second is lost while loading
   task automatic set_time(input logic [7:0] h, input logic [7:0] m, input logic [7:0] s, input logic [7:0] d,
                           input logic [7:0] mo, input logic [7:0] y, input logic [7:0] wd);
      wait_tick();
      wr_word(`ADDR_SET_MS, {m, s}, 1'b0);
      wr_word(`ADDR_SET_DH, {d, h}, 1'b0);
      wr_word(`ADDR_SET_YM, {y, mo}, 1'b0);
      wr_word(`ADDR_SET_WD, {8'h00, wd}, 1'b0);
      wr_word(`ADDR_CTRL, 16'h8000, 1'b0);
      settle();
      chk("hour minute", {time_r.hour, time_r.min}, {h, m});
      chk("seconds", {8'h00, time_r.sec}, {8'h00, s});
      chk("day month", {time_r.day, time_r.month}, {d, mo});
      chk("year weekday", {time_r.year, time_r.wday}, {y, wd});
   endtask

   // ***********************************************************
   // tests
   // ***********************************************************
   initial begin
      errors = 0;
      n_checks = 0;
      reset = 1'b1;
      wr_req = '0;
      rd_addr = '0;
      repeat (12) @(posedge ref_clk);
      @(negedge ref_clk);
      reset = 1'b0;

      for (int i = 0; i < 6; i++) begin
         rd_word(`ADDR_MONITOR + 17'(i), rd_val);
         chk("reset word", rd_val, rst_tab[i]);
      end
      rd_word(`ADDR_CTRL + 17'h00001, rd_val);
      chk("unmapped read", rd_val, 16'h0000);
      $display("test reset values done");

      set_time(8'h12, 8'h00, 8'h00, 8'h05, 8'h07, 8'h24, 8'h04);
      rd_word(`ADDR_CTRL, rd_val);
      chk("control after load", rd_val, 16'h0000);
      rd_word(`ADDR_SET_DH, rd_val);
      chk("day hour word", rd_val, 16'h0512);
      rd_word(`ADDR_MONITOR, rd_val);
      chk("monitor", rd_val, 16'h1200);
      wr_word(`ADDR_MONITOR, 16'h3333, 1'b0);
      rd_word(`ADDR_MONITOR, rd_val);
      chk("monitor after write", rd_val, 16'h1200);
      $display("test load and monitor done");

      // last second of a day across month, leap and year ends
      for (int i = 0; i < 7; i++) begin
         set_time(8'h23, 8'h59, 8'h59, roll_tab[i][47:40], roll_tab[i][39:32], roll_tab[i][31:24], 8'(i));
         adv();
         chk("time after rollover", {time_r.hour, time_r.min}, 16'h0000);
         chk("seconds after rollover", {8'h00, time_r.sec}, 16'h0000);
         chk("date after rollover", {time_r.day, time_r.month}, roll_tab[i][23:8]);
         chk("year after rollover", {8'h00, time_r.year}, {8'h00, roll_tab[i][7:0]});
         chk("weekday after rollover", {8'h00, time_r.wday}, (i == 6) ? 16'h0000 : 16'(i + 1));
      end
      $display("test calendar rollover done");

      for (int i = 0; i < 4; i++) begin
         set_time(8'h10, round_tab[i][31:24], round_tab[i][23:16], 8'h15, 8'h06, 8'h23, 8'h02);
         wr_word(`ADDR_CTRL, 16'h0001, 1'b0);
         settle();
         chk("seconds after rounding", {8'h00, time_r.sec}, 16'h0000);
         chk("time after rounding", {time_r.hour, time_r.min}, round_tab[i][15:0]);
         rd_word(`ADDR_CTRL, rd_val);
         chk("control after rounding", rd_val, 16'h0000);
      end
      $display("test seconds rounding done");

      // plain control value is only stored, so the tool load must leave it alone
      wait_tick();
      wr_word(`ADDR_CTRL, 16'h0010, 1'b0);
      wr_word(`ADDR_SET_MS, 16'h1530, 1'b1);
      settle();
      chk("minute second by tool", {time_r.min, time_r.sec}, 16'h1530);
      chk("hour by tool", {8'h00, time_r.hour}, 16'h0010);
      rd_word(`ADDR_CTRL, rd_val);
      chk("control after tool", rd_val, 16'h0010);
      wr_word(`ADDR_SET_MS, 16'h4444, 1'b0);
      settle();
      chk("program write no load", {time_r.min, time_r.sec}, 16'h1530);
      // both action bits: the load is taken and no rounding follows
      wr_word(`ADDR_CTRL, 16'h8001, 1'b0);
      settle();
      chk("minute second after dual action", {time_r.min, time_r.sec}, 16'h4444);
      rd_word(`ADDR_CTRL, rd_val);
      chk("control after dual action", rd_val, 16'h0000);
      $display("test tool path done");

      end_sim();
   end

   // ***********************************************************
   // watchdog
   // ***********************************************************
   // about 25 seconds of SEC_N cycles are used; allow several times that
   initial begin
      repeat (150 * SEC_N) @(posedge ref_clk);
      errors++;
      $display("watchdog expired");
      end_sim();
   end

endmodule // test_cal_clock
`default_nettype wire
